// File: src/id_code_access_gate.sv
// Purpose: decides whether serial programmer / debug emulator commands are accepted
// Assumes: received id bytes and commands arrive as one-cycle strobes on core_clk
// Notes:   decision taken once per reset, after the stored image and all seven bytes are in
// Functional notes
// - seven id bytes live at fixed vector-table flash addresses
// - compare received and stored id; accept commands on match only
// - blank reset vector skips the id check and accepts everything unless the stored id is the serial-disable keyword
// - forced-erase keyword is a fixed seven byte sequence
// - serial-disable keyword is a fixed seven byte sequence
// - a keyword counts only when all seven bytes match exactly
// - both ids forced-erase keyword: erase whole user rom
// - received erase keyword, stored other: erase unless protect bits equal 01b
// - stored erase keyword, received other: mismatch, no command accepted
// - stored serial-disable keyword refuses all tool communication
// - serial-disable plus rom protect also blocks parallel programmer access
// - cpu stores cannot alter id locations
// - gate bit b2 enables lock bit b3; b3 zero means protected
`timescale 1ns/1ps
module id_code_access_gate
   import id_gate_pkg::*;
(
   input  wire  logic                core_clk,
   input  wire  logic                rst,
   input  wire  logic                flashRdAck,
   input  wire  logic [7:0]          flashRdData,
   output logic                      flashRdReq,
   output id_gate_pkg::faddr_t       flashRdAddr,
   input  wire  logic                idRxValid,
   input  wire  logic [7:0]          idRxByte,
   input  wire  logic                cmdValid,
   output logic                      cmdAck,
   output logic                      cmdNak,
   output logic                      idMatch,
   output logic                      serialBlocked,
   output logic                      parallelBlocked,
   output logic                      eraseReq,
   output logic                      eraseBusy,
   input  wire  logic                eraseDone,
   input  wire  logic                cpuStoreReq,
   input  wire  id_gate_pkg::faddr_t cpuStoreAddr,
   output logic                      cpuStoreDeny
);
   import id_gate_pkg::*;

   typedef enum logic [2:0] {
      ST_COLLECT,
      ST_DECIDE,
      ST_ERASE,
      ST_OPEN,
      ST_REFUSE,
      ST_DISABLED
   } gate_e;

   idvec_t      storedId;
   idvec_t      rxId_ff,    nxt_rxId;
   logic [23:0] resetVec;
   logic [7:0]  optionSelectByte;
   logic        loadDone;
   logic        storedErase;
   logic        storedDisable;
   logic        rxErase;
   logic        rxDisable;

   id_flash_loader uLoader (
      .core_clk         (core_clk),
      .rst              (rst),
      .flashRdAck       (flashRdAck),
      .flashRdData      (flashRdData),
      .flashRdReq       (flashRdReq),
      .flashRdAddr      (flashRdAddr),
      .storedId         (storedId),
      .resetVec         (resetVec),
      .optionSelectByte (optionSelectByte),
      .loadDone         (loadDone)
   );

   id_keyword_match uStoredMatch (
      .idBytes   (storedId),
      .isErase   (storedErase),
      .isDisable (storedDisable)
   );

   id_keyword_match uRxMatch (
      .idBytes   (rxId_ff),
      .isErase   (rxErase),
      .isDisable (rxDisable)
   );

   // protection decode from the option select byte
   logic protectGateBit;
   logic romLockBit;
   logic protectOn;
   logic blankVector;

   assign protectGateBit = optionSelectByte[OPT_GATE_POS];
   assign romLockBit     = optionSelectByte[OPT_LOCK_POS];
   assign protectOn      = ({romLockBit, protectGateBit} == PROTECT_ON);
   assign blankVector    = (resetVec == RSTV_BLANK);

   // ---------------- received id collection and session state
   gate_e       state_ff,   nxt_state;
   logic [2:0]  rxCnt_ff,   nxt_rxCnt;
   logic        rxFull_ff,  nxt_rxFull;
   logic        match_ff,   nxt_match;
   logic        sBlock_ff,  nxt_sBlock;
   logic        pBlock_ff,  nxt_pBlock;
   logic        eReq_ff,    nxt_eReq;

   always_comb begin
      nxt_state  = state_ff;
      nxt_rxId   = rxId_ff;
      nxt_rxCnt  = rxCnt_ff;
      nxt_rxFull = rxFull_ff;
      nxt_match  = match_ff;
      nxt_sBlock = sBlock_ff;
      nxt_pBlock = pBlock_ff;
      nxt_eReq   = 1'b0;
      unique case (state_ff)
         ST_COLLECT: begin
            if (idRxValid && !rxFull_ff) begin
               nxt_rxId[rxCnt_ff] = idRxByte;
               if (rxCnt_ff == CNT_LAST) begin
                  nxt_rxFull = 1'b1;
               end else begin
                  nxt_rxCnt = rxCnt_ff + 3'h1;
               end
            end
            if (rxFull_ff && loadDone) begin
               nxt_state = ST_DECIDE;
            end
         end
         ST_DECIDE: begin
            nxt_pBlock = storedDisable && protectOn;
            if (storedDisable) begin
               nxt_sBlock = 1'b1;
               nxt_state  = ST_DISABLED;
            end else if (blankVector) begin
               nxt_match = 1'b1;
               nxt_state = ST_OPEN;
            end else if (rxErase && (storedErase || !protectOn)) begin
               nxt_eReq  = 1'b1;
               nxt_state = ST_ERASE;
            end else if (storedErase) begin
               nxt_state = ST_REFUSE;
            end else if (rxId_ff == storedId) begin
               nxt_match = 1'b1;
               nxt_state = ST_OPEN;
            end else begin
               nxt_state = ST_REFUSE;
            end
         end
         ST_ERASE: begin
            if (eraseDone) begin
               nxt_match = 1'b1;
               nxt_state = ST_OPEN;
            end
         end
         ST_OPEN: begin
            nxt_state = ST_OPEN;
         end
         ST_REFUSE: begin
            nxt_state = ST_REFUSE;
         end
         ST_DISABLED: begin
            nxt_state = ST_DISABLED;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_ff  <= ST_COLLECT;
         rxId_ff   <= '0;
         rxCnt_ff  <= CNT_RESET;
         rxFull_ff <= 1'b0;
         match_ff  <= 1'b0;
         sBlock_ff <= 1'b0;
         pBlock_ff <= 1'b0;
         eReq_ff   <= 1'b0;
      end else begin
         state_ff  <= nxt_state;
         rxId_ff   <= nxt_rxId;
         rxCnt_ff  <= nxt_rxCnt;
         rxFull_ff <= nxt_rxFull;
         match_ff  <= nxt_match;
         sBlock_ff <= nxt_sBlock;
         pBlock_ff <= nxt_pBlock;
         eReq_ff   <= nxt_eReq;
      end
   end

   // ---------------- command answers and cpu store guard
   logic ack_ff,   nxt_ack;
   logic nak_ff,   nxt_nak;
   logic deny_ff,  nxt_deny;
   logic busy_ff,  nxt_busy;

   always_comb begin
      nxt_ack  = 1'b0;
      nxt_nak  = 1'b0;
      nxt_busy = (nxt_state == ST_ERASE);
      if (cmdValid) begin
         if (state_ff == ST_OPEN) begin
            nxt_ack = 1'b1;
         end else begin
            nxt_nak = 1'b1;
         end
      end
      nxt_deny = cpuStoreReq && isGuardedAddr(cpuStoreAddr);
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         ack_ff  <= 1'b0;
         nak_ff  <= 1'b0;
         deny_ff <= 1'b0;
         busy_ff <= 1'b0;
      end else begin
         ack_ff  <= nxt_ack;
         nak_ff  <= nxt_nak;
         deny_ff <= nxt_deny;
         busy_ff <= nxt_busy;
      end
   end

   assign cmdAck          = ack_ff;
   assign cmdNak          = nak_ff;
   assign idMatch         = match_ff;
   assign serialBlocked   = sBlock_ff;
   assign parallelBlocked = pBlock_ff;
   assign eraseReq        = eReq_ff;
   assign eraseBusy       = busy_ff;
   assign cpuStoreDeny    = deny_ff;

   // unused keyword flag of the received id is intentionally not a decision input
   logic rxDisableUnused;
   assign rxDisableUnused = rxDisable;

endmodule : id_code_access_gate

// File: src/id_gate_pkg.sv
// Purpose: shared constants and types for the id code access gate
// Assumes: 20-bit flash byte addresses, byte-wide flash read port
// Notes:   index 0 of every id vector is the first (lowest address) byte
package id_gate_pkg;

   localparam int ID_LEN     = 7;
   localparam int FETCH_LEN  = 11;

   typedef logic [ID_LEN-1:0][7:0] idvec_t;
   typedef logic [19:0]            faddr_t;
   typedef logic [3:0]             fidx_t;

   // id byte locations, first at index 0
   localparam faddr_t ID_ADDR_0   = 20'h0ffdf;
   localparam faddr_t ID_ADDR_1   = 20'h0ffe3;
   localparam faddr_t ID_ADDR_2   = 20'h0ffeb;
   localparam faddr_t ID_ADDR_3   = 20'h0ffef;
   localparam faddr_t ID_ADDR_4   = 20'h0fff3;
   localparam faddr_t ID_ADDR_5   = 20'h0fff7;
   localparam faddr_t ID_ADDR_6   = 20'h0fffb;
   // reset vector low..high, then the option select byte
   localparam faddr_t RSTV_ADDR_0 = 20'h0fffc;
   localparam faddr_t RSTV_ADDR_1 = 20'h0fffd;
   localparam faddr_t RSTV_ADDR_2 = 20'h0fffe;
   localparam faddr_t OPT_ADDR    = 20'h0ffff;

   localparam fidx_t  IDX_RSTV_0  = 4'h7;
   localparam fidx_t  IDX_OPT     = 4'ha;

   localparam logic [23:0] RSTV_BLANK = 24'hffffff;

   localparam idvec_t KEY_ERASE   = {8'h45, 8'h53, 8'h41, 8'h52, 8'h65, 8'h4c, 8'h41};
   localparam idvec_t KEY_DISABLE = {8'h74, 8'h63, 8'h65, 8'h74, 8'h6f, 8'h72, 8'h50};

   // option select byte fields
   localparam int OPT_GATE_POS  = 2;
   localparam int OPT_LOCK_POS  = 3;
   localparam logic [1:0] PROTECT_ON = 2'b01;  // {lock, gate}

   localparam logic [7:0]  OPT_RESET  = 8'hff;
   localparam logic [23:0] RSTV_RESET = 24'h000000;
   localparam logic [2:0]  CNT_RESET  = 3'h0;
   localparam logic [2:0]  CNT_LAST   = 3'h6;

   function automatic faddr_t fetchAddr(input fidx_t idx);
      faddr_t a;
      a = OPT_ADDR;
      unique case (idx)
         4'h0:    a = ID_ADDR_0;
         4'h1:    a = ID_ADDR_1;
         4'h2:    a = ID_ADDR_2;
         4'h3:    a = ID_ADDR_3;
         4'h4:    a = ID_ADDR_4;
         4'h5:    a = ID_ADDR_5;
         4'h6:    a = ID_ADDR_6;
         4'h7:    a = RSTV_ADDR_0;
         4'h8:    a = RSTV_ADDR_1;
         4'h9:    a = RSTV_ADDR_2;
         default: a = OPT_ADDR;
      endcase
      return a;
   endfunction : fetchAddr

   function automatic logic isGuardedAddr(input faddr_t a);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < FETCH_LEN; i++) begin
         if (a == fetchAddr(fidx_t'(i))) begin
            hit = 1'b1;
         end
      end
      return hit;
   endfunction : isGuardedAddr

endpackage : id_gate_pkg

// File: src/id_keyword_match.sv
// Purpose: flags whether a seven byte id equals one of the two keywords
// Assumes: purely combinational, used for stored and received ids
// Notes:   every byte must match, a partial match is an ordinary id
`timescale 1ns/1ps
module id_keyword_match
   import id_gate_pkg::*;
(
   input  wire id_gate_pkg::idvec_t idBytes,
   output logic                     isErase,
   output logic                     isDisable
);
   logic [ID_LEN-1:0] eraseHit;
   logic [ID_LEN-1:0] disableHit;

   genvar g;
   generate
      for (g = 0; g < ID_LEN; g++) begin : gByte
         assign eraseHit[g]   = (idBytes[g] == KEY_ERASE[g]);
         assign disableHit[g] = (idBytes[g] == KEY_DISABLE[g]);
      end
   endgenerate

   assign isErase   = &eraseHit;
   assign isDisable = &disableHit;

endmodule : id_keyword_match

// File: src/id_flash_loader.sv
// Purpose: fetches id bytes, reset vector and option byte from flash
// Assumes: flash answers a held request with a one cycle ack carrying data
// Notes:   stored values change only through this fetch
`timescale 1ns/1ps
module id_flash_loader
   import id_gate_pkg::*;
(
   input  wire logic                core_clk,
   input  wire logic                rst,
   input  wire logic                flashRdAck,
   input  wire logic [7:0]          flashRdData,
   output logic                     flashRdReq,
   output id_gate_pkg::faddr_t      flashRdAddr,
   output id_gate_pkg::idvec_t      storedId,
   output logic [23:0]              resetVec,
   output logic [7:0]               optionSelectByte,
   output logic                     loadDone
);
   fidx_t       idx_ff,    nxt_idx;
   logic        done_ff,   nxt_done;
   idvec_t      id_ff,     nxt_id;
   logic [23:0] rstv_ff,   nxt_rstv;
   logic [7:0]  opt_ff,    nxt_opt;
   faddr_t      addr_ff,   nxt_addr;

   always_comb begin
      nxt_idx  = idx_ff;
      nxt_done = done_ff;
      nxt_id   = id_ff;
      nxt_rstv = rstv_ff;
      nxt_opt  = opt_ff;
      if (!done_ff && flashRdAck) begin
         if (idx_ff < IDX_RSTV_0) begin
            nxt_id[idx_ff[2:0]] = flashRdData;
         end else if (idx_ff < IDX_OPT) begin
            nxt_rstv[8*(idx_ff - IDX_RSTV_0) +: 8] = flashRdData;
         end else begin
            nxt_opt = flashRdData;
         end
         if (idx_ff == IDX_OPT) begin
            nxt_done = 1'b1;
         end else begin
            nxt_idx = idx_ff + 4'h1;
         end
      end
      nxt_addr = fetchAddr(nxt_idx);
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         idx_ff  <= 4'h0;
         done_ff <= 1'b0;
         id_ff   <= '0;
         rstv_ff <= RSTV_RESET;
         opt_ff  <= OPT_RESET;
         addr_ff <= ID_ADDR_0;
      end else begin
         addr_ff <= nxt_addr;
         idx_ff  <= nxt_idx;
         done_ff <= nxt_done;
         id_ff   <= nxt_id;
         rstv_ff <= nxt_rstv;
         opt_ff  <= nxt_opt;
      end
   end

   assign flashRdReq       = ~done_ff;
   assign flashRdAddr      = addr_ff;
   assign storedId         = id_ff;
   assign resetVec         = rstv_ff;
   assign optionSelectByte = opt_ff;
   assign loadDone         = done_ff;

endmodule : id_flash_loader

// File: tb/id_code_access_gate_chk.sv
// Purpose: port-level checks of the id code access gate
// Assumes: one core_clk domain, rst synchronous active high
// Notes:   bound to every instance of the gate
`timescale 1ns/1ps
module id_code_access_gate_chk (
   input wire logic                core_clk,
   input wire logic                rst,
   input wire logic                flashRdReq,
   input wire logic                flashRdAck,
   input wire id_gate_pkg::faddr_t flashRdAddr,
   input wire logic                cmdValid,
   input wire logic                cmdAck,
   input wire logic                cmdNak,
   input wire logic                idMatch,
   input wire logic                serialBlocked,
   input wire logic                parallelBlocked,
   input wire logic                eraseReq,
   input wire logic                eraseBusy,
   input wire logic                eraseDone,
   input wire logic                cpuStoreReq,
   input wire id_gate_pkg::faddr_t cpuStoreAddr,
   input wire logic                cpuStoreDeny
);
   import id_gate_pkg::*;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   logic guarded;
   assign guarded = cpuStoreAddr inside {ID_ADDR_0, ID_ADDR_1, ID_ADDR_2, ID_ADDR_3, ID_ADDR_4, ID_ADDR_5,
                                         ID_ADDR_6, RSTV_ADDR_0, RSTV_ADDR_1, RSTV_ADDR_2, OPT_ADDR};
   sequence s_erase_start;
      $rose(eraseReq) ##0 eraseBusy;
   endsequence
   sequence s_erase_end;
      eraseBusy && eraseDone;
   endsequence
   a_cmd_answer: assert property (cmdValid |=> cmdAck != cmdNak)
      else $error("command not answered exactly once");
   a_nak_closed: assert property (cmdValid && !idMatch |=> cmdNak)
      else $error("command accepted without access");
   a_ack_open: assert property (cmdValid && idMatch && !eraseBusy |=> cmdAck)
      else $error("command refused while open");
   a_block_shut: assert property (serialBlocked |-> !idMatch && !eraseBusy)
      else $error("blocked gate still open");
   a_parallel_needs: assert property (parallelBlocked |-> serialBlocked)
      else $error("parallel block without serial block");
   a_erase_begin: assert property (eraseReq |-> s_erase_start ##1 !eraseReq)
      else $error("erase request malformed");
   a_erase_finish: assert property (s_erase_end |=> !eraseBusy && idMatch)
      else $error("erase end not granting access");
   a_fetch_hold: assert property (flashRdReq && !flashRdAck |=> flashRdReq && $stable(flashRdAddr))
      else $error("fetch request dropped before ack");
   a_fetch_order: assert property (flashRdAck && flashRdAddr == ID_ADDR_6 |=> flashRdAddr == RSTV_ADDR_0)
      else $error("fetch order wrong after last id");
   a_open_after_load: assert property ($rose(idMatch) |-> !flashRdReq)
      else $error("access granted before load");
   a_store_deny: assert property (cpuStoreReq |=> cpuStoreDeny == $past(guarded))
      else $error("cpu store guard wrong");
endmodule : id_code_access_gate_chk

bind id_code_access_gate id_code_access_gate_chk chk_u (.core_clk, .rst, .flashRdReq, .flashRdAck,
   .flashRdAddr, .cmdValid, .cmdAck, .cmdNak, .idMatch, .serialBlocked, .parallelBlocked, .eraseReq,
   .eraseBusy, .eraseDone, .cpuStoreReq, .cpuStoreAddr, .cpuStoreDeny);

// File: tb/flash_image_model.sv
// Purpose: flash read port holding the vector table image
// Assumes: one cycle ack after a random wait
// Notes:   data off ack shows the inverse of the last byte
`timescale 1ns/1ps
module flash_image_model (
   input  wire logic                core_clk,
   input  wire logic                rst,
   input  wire logic                flashRdReq,
   input  wire id_gate_pkg::faddr_t flashRdAddr,
   input  wire id_gate_pkg::idvec_t imgId,
   input  wire logic [23:0]         imgRstv,
   input  wire logic [7:0]          imgOpt,
   output logic                     flashRdAck,
   output logic [7:0]               flashRdData
);
   import id_gate_pkg::*;
   logic [7:0] img;
   logic [7:0] lastByte_ff;
   always_comb begin
      case (flashRdAddr)
         ID_ADDR_0:   img = imgId[0];
         ID_ADDR_1:   img = imgId[1];
         ID_ADDR_2:   img = imgId[2];
         ID_ADDR_3:   img = imgId[3];
         ID_ADDR_4:   img = imgId[4];
         ID_ADDR_5:   img = imgId[5];
         ID_ADDR_6:   img = imgId[6];
         RSTV_ADDR_0: img = imgRstv[7:0];
         RSTV_ADDR_1: img = imgRstv[15:8];
         RSTV_ADDR_2: img = imgRstv[23:16];
         OPT_ADDR:    img = imgOpt;
         default:     img = 8'hff;
      endcase
   end
   // image is read only, no write path
   always_ff @(posedge core_clk) begin
      if (rst) begin
         flashRdAck <= 1'b0;
      end else begin
         flashRdAck <= flashRdReq && !flashRdAck && ($urandom_range(0, 2) != 0);
      end
      if (flashRdAck) begin
         lastByte_ff <= img;
      end
   end
   assign flashRdData = flashRdAck ? img : ~lastByte_ff;
endmodule : flash_image_model

// File: tb/tb_id_code_access_gate.sv
// Purpose: self-checking bench of the id code access gate
// Assumes: inputs driven at falling edge of core_clk
// Notes:   one decision per reset, so every case resets
`timescale 1ns/1ps
module tb_id_code_access_gate;
   import id_gate_pkg::*;
   localparam idvec_t KW_ERASE   = {8'h45, 8'h53, 8'h41, 8'h52, 8'h65, 8'h4c, 8'h41};
   localparam idvec_t KW_DISABLE = {8'h74, 8'h63, 8'h65, 8'h74, 8'h6f, 8'h72, 8'h50};
   logic core_clk, rst, flashRdAck, flashRdReq, idRxValid, cmdValid, cmdAck, cmdNak, idMatch;
   logic serialBlocked, parallelBlocked, eraseReq, eraseBusy, eraseDone, cpuStoreReq, cpuStoreDeny;
   logic [7:0]  flashRdData, idRxByte, imgOpt;
   logic [23:0] imgRstv, rv;
   faddr_t      flashRdAddr, cpuStoreAddr;
   idvec_t      imgId, rr, r2, pe, pd;
   faddr_t      gAddr[11] = '{ID_ADDR_0, ID_ADDR_1, ID_ADDR_2, ID_ADDR_3, ID_ADDR_4, ID_ADDR_5, ID_ADDR_6,
                              RSTV_ADDR_0, RSTV_ADDR_1, RSTV_ADDR_2, OPT_ADDR};
   int          n_fail = 0;
   int          num_checks = 0;

   id_code_access_gate dut_u (.core_clk, .rst, .flashRdAck, .flashRdData, .flashRdReq, .flashRdAddr,
      .idRxValid, .idRxByte, .cmdValid, .cmdAck, .cmdNak, .idMatch, .serialBlocked, .parallelBlocked,
      .eraseReq, .eraseBusy, .eraseDone, .cpuStoreReq, .cpuStoreAddr, .cpuStoreDeny);
   flash_image_model mdl_u (.core_clk, .rst, .flashRdReq, .flashRdAddr, .imgId, .imgRstv, .imgOpt,
      .flashRdAck, .flashRdData);

   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end

   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic conclude();
      if (n_fail == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : conclude

   // 0 refuse, 1 accept, 2 forced erase
   function automatic logic [1:0] expAct(input idvec_t st, input idvec_t rx, input logic [23:0] rvi,
                                          input logic prot);
      if (st == KW_DISABLE) return 2'd0;
      if (rvi == 24'hffffff) return 2'd1;
      if (rx == KW_ERASE && (st == KW_ERASE || !prot)) return 2'd2;
      return (rx == st) ? 2'd1 : 2'd0;
   endfunction : expAct

   task automatic sendCmd(input logic ok);
      @(negedge core_clk) cmdValid = 1'b1;
      @(negedge core_clk) cmdValid = 1'b0;
      check(24'(cmdAck), 24'(ok));
      check(24'(cmdNak), 24'(!ok));
   endtask : sendCmd

   task automatic runCase(input idvec_t st, input idvec_t rx, input logic [23:0] rvi, input logic [7:0] op);
      logic [1:0] act;
      logic       prot;
      logic       g;
      int         w;
      imgId = st;
      imgRstv = rvi;
      imgOpt = op;
      prot = {op[3], op[2]} == 2'b01;
      act = expAct(st, rx, rvi, prot);
      @(negedge core_clk) rst = 1'b1;
      repeat (4) @(negedge core_clk);
      rst = 1'b0;
      sendCmd(1'b0);
      for (int k = 0; k < 8; k++) begin
         @(negedge core_clk) idRxValid = 1'b1;
         idRxByte = (k < 7) ? rx[k] : ~rx[0];
      end
      @(negedge core_clk) idRxValid = 1'b0;
      w = 0;
      while (flashRdReq !== 1'b0 && w < 300) begin
         @(negedge core_clk);
         w++;
      end
      repeat (3) @(negedge core_clk);
      check(24'(serialBlocked), 24'(st == KW_DISABLE));
      check(24'(parallelBlocked), 24'(st == KW_DISABLE && prot));
      check(24'(eraseBusy), 24'(act == 2'd2));
      if (act == 2'd2) begin
         sendCmd(1'b0);
         repeat ($urandom_range(0, 5)) @(negedge core_clk);
         eraseDone = 1'b1;
         @(negedge core_clk) eraseDone = 1'b0;
         check(24'(eraseBusy), 24'h0);
      end
      check(24'(idMatch), 24'(act != 2'd0));
      sendCmd(act != 2'd0);
      g = 1'($urandom_range(0, 1));
      @(negedge core_clk) cpuStoreReq = 1'b1;
      cpuStoreAddr = g ? gAddr[$urandom_range(0, 10)] : 20'h04000 + 20'($urandom_range(0, 255));
      @(negedge core_clk) cpuStoreReq = 1'b0;
      check(24'(cpuStoreDeny), 24'(g));
   endtask : runCase

   initial begin
      void'($urandom(87));
      {rst, idRxValid, cmdValid, eraseDone, cpuStoreReq} = 5'h10;
      idRxByte = 8'h00;
      cpuStoreAddr = 20'h00000;
      imgId = '1;
      imgRstv = 24'h000000;
      imgOpt = 8'hff;
      repeat (4) @(negedge core_clk);
      rst = 1'b0;
      pe = KW_ERASE;
      pe[0] = 8'h61;
      pd = KW_DISABLE;
      pd[6] = 8'h75;
      for (int i = 0; i < 18; i++) begin
         rr = 56'({$urandom, $urandom});
         r2 = rr;
         r2[3][0] = ~r2[3][0];
         rv = 24'($urandom) & 24'h7fffff;
         case (i)
            0: runCase(rr, rr, rv, 8'hff);
            1: runCase(rr, r2, rv, 8'hff);
            2: runCase(rr, r2, 24'hffffff, 8'hff);
            3: runCase(KW_ERASE, KW_ERASE, rv, 8'hf7);
            4: runCase(rr, KW_ERASE, rv, 8'hf7);
            5: runCase(rr, KW_ERASE, rv, 8'hf3);
            6: runCase(KW_ERASE, rr, rv, 8'hff);
            7: runCase(KW_DISABLE, KW_DISABLE, rv, 8'hf7);
            8: runCase(KW_DISABLE, KW_DISABLE, 24'hffffff, 8'hff);
            9: runCase(pd, pd, rv, 8'hf7);
            10: runCase(pe, pe, rv, 8'hff);
            default: runCase(rr, $urandom_range(0, 1) ? rr : r2, rv, 8'($urandom));
         endcase
      end
      conclude();
   end

   initial begin
      #500000;
      n_fail++;
      conclude();
   end
endmodule : tb_id_code_access_gate
